// [rtl/pll_divider_config.sv]
// pll divider configuration slice: pump mode, power-down, r/a/b dividers
// assumes the serial control port delivers decoded byte reads and writes
import pll_cfg_pkg::*;

// Overview of operation
// - pump mode: hiz, source, sink, normal
// - power-down: normal, async, unused, sync
// - 14-bit reference divider over 0x011, 0x012
// - reference low byte resets to 0x01
// - reference upper six bits reset zero
// - a counter six bits at 0x013
// - b counter low byte 0x014, resets 0x03
// - b counter upper five bits at 0x015
module pll_divider_config
	import pll_cfg_pkg::*;
(
	input  wire logic       clk_sys_i, // system clock
	input  wire logic       nrst_i,    // sync reset, active low
	input  wire reg_req_s   req_i,     // byte register request
	output logic [7:0]      rdata_o,   // read data, one cycle after rd
	output logic            rvalid_o,  // read data valid pulse
	output pll_ctrl_s       ctrl_o     // decoded loop controls
);

	typedef struct packed {
		logic      rvalid;
		pll_ctrl_s ctrl;
	} state_s;

	state_s st;
	state_s next_st;

	logic [2:0]      idx;
	logic [7:0]      wmask;
	logic [47:0]     flat;
	logic [5:0][7:0] bytes;

	// ==========================================================
	// address decode and write masking
	always_comb begin
		idx = reg_index(req_i.addr);
		unique case (idx)
			3'h0: wmask = MASK_PUMP_POWER;
			3'h1: wmask = MASK_FULL;
			3'h2: wmask = MASK_SIX;
			3'h3: wmask = MASK_SIX;
			3'h4: wmask = MASK_FULL;
			3'h5: wmask = MASK_FIVE;
			default: wmask = 8'h00;
		endcase
	end

	pll_cfg_regfile u_regs (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.we_i      (req_i.wr),
		.idx_i     (idx),
		.wdata_i   (req_i.wdata & wmask),
		.rdata_o   (rdata_o),
		.flat_o    (flat)
	);

	assign bytes = flat;

	// ==========================================================
	// field decode; registered so controls never glitch
	always_comb begin
		pump_operating_select_e pump;
		power_down_e            pwr;
		pump    = pump_operating_select_e'(bytes[0][PUMP_MODE_LSB +: 2]);
		pwr     = power_down_e'(bytes[0][POWER_LSB +: 2]);
		next_st = st;
		next_st.rvalid = req_i.rd;
		unique case (pump)
			PUMP_HIGH_Z: begin
				next_st.ctrl.charge_pump_up   = 1'b0;
				next_st.ctrl.charge_pump_down = 1'b0;
				next_st.ctrl.charge_pump_hiz  = 1'b1;
			end
			PUMP_SOURCE: begin
				next_st.ctrl.charge_pump_up   = 1'b1;
				next_st.ctrl.charge_pump_down = 1'b0;
				next_st.ctrl.charge_pump_hiz  = 1'b0;
			end
			PUMP_SINK: begin
				next_st.ctrl.charge_pump_up   = 1'b0;
				next_st.ctrl.charge_pump_down = 1'b1;
				next_st.ctrl.charge_pump_hiz  = 1'b0;
			end
			PUMP_NORMAL: begin
				next_st.ctrl.charge_pump_up   = 1'b1;
				next_st.ctrl.charge_pump_down = 1'b1;
				next_st.ctrl.charge_pump_hiz  = 1'b0;
			end
		endcase
		// unused code keeps the loop off but is not a power-down
		next_st.ctrl.pll_enable       = (pwr == PWR_NORMAL);
		next_st.ctrl.async_power_down = (pwr == PWR_ASYNC_PD);
		next_st.ctrl.sync_power_down  = (pwr == PWR_SYNC_PD);
		next_st.ctrl.ref_divide = {bytes[2][5:0], bytes[1]};
		next_st.ctrl.a_count    = bytes[3][5:0];
		next_st.ctrl.b_count    = {bytes[5][4:0], bytes[4]};
	end

	// reset state mirrors the register defaults
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st.rvalid                <= 1'b0;
			st.ctrl.charge_pump_up   <= 1'b1;
			st.ctrl.charge_pump_down <= 1'b1;
			st.ctrl.charge_pump_hiz  <= 1'b0;
			st.ctrl.pll_enable       <= 1'b0;
			st.ctrl.async_power_down <= 1'b1;
			st.ctrl.sync_power_down  <= 1'b0;
			st.ctrl.ref_divide       <= {RST_REF_HIGH[5:0], RST_REF_LOW};
			st.ctrl.a_count          <= RST_A_COUNT[5:0];
			st.ctrl.b_count          <= {RST_B_HIGH[4:0], RST_B_LOW};
		end else begin
			st <= next_st;
		end
	end

	assign rvalid_o = st.rvalid;
	assign ctrl_o   = st.ctrl;

endmodule : pll_divider_config

// [rtl/pll_cfg_pkg.sv]
// package for the pll divider configuration slice
// assumes a byte-wide register port at the serial control port's decode
package pll_cfg_pkg;

	// ==========================================================
	// register offsets
	localparam logic [9:0] ADDR_PUMP_POWER = 10'h010;
	localparam logic [9:0] ADDR_REF_LOW    = 10'h011;
	localparam logic [9:0] ADDR_REF_HIGH   = 10'h012;
	localparam logic [9:0] ADDR_A_COUNT    = 10'h013;
	localparam logic [9:0] ADDR_B_LOW      = 10'h014;
	localparam logic [9:0] ADDR_B_HIGH     = 10'h015;
	localparam int         REG_COUNT       = 6;

	// ==========================================================
	// field positions and masks
	localparam int         PUMP_MODE_LSB = 2;
	localparam int         POWER_LSB     = 0;
	localparam logic [7:0] MASK_PUMP_POWER = 8'hff;
	localparam logic [7:0] MASK_SIX        = 8'h3f;
	localparam logic [7:0] MASK_FIVE       = 8'h1f;
	localparam logic [7:0] MASK_FULL       = 8'hff;

	// ==========================================================
	// values after reset (upper pump bits: pfd positive, current max)
	localparam logic [7:0] RST_PUMP_POWER = 8'h7d;
	localparam logic [7:0] RST_REF_LOW    = 8'h01;
	localparam logic [7:0] RST_REF_HIGH   = 8'h00;
	localparam logic [7:0] RST_A_COUNT    = 8'h00;
	localparam logic [7:0] RST_B_LOW      = 8'h03;
	localparam logic [7:0] RST_B_HIGH     = 8'h00;

	// ==========================================================
	// modes
	typedef enum logic [1:0] {
		PUMP_HIGH_Z  = 2'b00,
		PUMP_SOURCE  = 2'b01,
		PUMP_SINK    = 2'b10,
		PUMP_NORMAL  = 2'b11
	} pump_operating_select_e;

	typedef enum logic [1:0] {
		PWR_NORMAL   = 2'b00,
		PWR_ASYNC_PD = 2'b01,
		PWR_UNUSED   = 2'b10,
		PWR_SYNC_PD  = 2'b11
	} power_down_e;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [9:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic        charge_pump_up;
		logic        charge_pump_down;
		logic        charge_pump_hiz;
		logic        pll_enable;
		logic        async_power_down;
		logic        sync_power_down;
		logic [13:0] ref_divide;
		logic [5:0]  a_count;
		logic [12:0] b_count;
	} pll_ctrl_s;

	// index of a mapped offset, REG_COUNT when unmapped
	function automatic logic [2:0] reg_index(input logic [9:0] addr);
		if (addr >= ADDR_PUMP_POWER && addr <= ADDR_B_HIGH) begin
			return 3'(addr - ADDR_PUMP_POWER);
		end
		return 3'(REG_COUNT);
	endfunction : reg_index

endpackage : pll_cfg_pkg

// [rtl/pll_cfg_regfile.sv]
// small register memory for the divider bytes
// assumes one write per cycle from the decoder; read data registered
module pll_cfg_regfile
	import pll_cfg_pkg::*;
(
	input  wire logic       clk_sys_i, // system clock
	input  wire logic       nrst_i,    // sync reset, active low
	input  wire logic       we_i,      // write strobe
	input  wire logic [2:0] idx_i,     // register index
	input  wire logic [7:0] wdata_i,   // write data, already masked
	output logic [7:0]      rdata_o,   // registered read data
	output logic [47:0]     flat_o     // all bytes, index 0 lowest
);

	typedef struct packed {
		logic [5:0][7:0] mem;
		logic [7:0]      rdata;
	} state_s;

	state_s st;
	state_s next_st;

	// ==========================================================
	// write and read path
	always_comb begin
		next_st = st;
		if (we_i && idx_i < 3'(REG_COUNT)) begin
			next_st.mem[idx_i] = wdata_i;
		end
		// unmapped index reads zero
		next_st.rdata = (idx_i < 3'(REG_COUNT)) ? st.mem[idx_i] : 8'h00;
	end

	// reset loads the documented defaults
	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			st.mem[0] <= RST_PUMP_POWER;
			st.mem[1] <= RST_REF_LOW;
			st.mem[2] <= RST_REF_HIGH;
			st.mem[3] <= RST_A_COUNT;
			st.mem[4] <= RST_B_LOW;
			st.mem[5] <= RST_B_HIGH;
			st.rdata  <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign flat_o  = st.mem;

endmodule : pll_cfg_regfile

// [verification/pll_divider_config_props.sv]
// checker for the pll divider configuration slice
// assumes ctrl_o follows a write two edges later, reads answer next cycle
module pll_divider_config_props
	import pll_cfg_pkg::*;
(
	input wire logic       clk_sys_i, // system clock
	input wire logic       nrst_i,    // sync reset, active low
	input wire reg_req_s   req_i,     // byte register request
	input wire logic [7:0] rdata_o,   // read data
	input wire logic       rvalid_o,  // read data valid
	input wire pll_ctrl_s  ctrl_o     // decoded controls
);
	// ==========================================================
	// a write is taken, stored, then shown on ctrl_o
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	sequence s_wr(logic [9:0] a);
		req_i.wr && req_i.addr == a;
	endsequence

	a_pump_mode_map: assert property (s_wr(ADDR_PUMP_POWER) |-> ##2
		{ctrl_o.charge_pump_down, ctrl_o.charge_pump_up, ctrl_o.charge_pump_hiz}
		== {$past(req_i.wdata[3:2], 2), $past(req_i.wdata[3:2], 2) == 2'b00})
		else $error("pump mode decode wrong");
	a_power_mode_map: assert property (s_wr(ADDR_PUMP_POWER) |-> ##2
		{ctrl_o.pll_enable, ctrl_o.async_power_down, ctrl_o.sync_power_down}
		== {$past(req_i.wdata[1:0], 2) == 2'b00, $past(req_i.wdata[1:0], 2) == 2'b01,
		$past(req_i.wdata[1:0], 2) == 2'b11}) else $error("power decode wrong");
	a_ref_low_byte: assert property (s_wr(ADDR_REF_LOW) |-> ##2
		ctrl_o.ref_divide[7:0] == $past(req_i.wdata, 2)) else $error("ref low wrong");
	a_ref_high_bits: assert property (s_wr(ADDR_REF_HIGH) |-> ##2
		ctrl_o.ref_divide[13:8] == $past(req_i.wdata[5:0], 2)) else $error("ref high wrong");
	a_a_count_bits: assert property (s_wr(ADDR_A_COUNT) |-> ##2
		ctrl_o.a_count == $past(req_i.wdata[5:0], 2)) else $error("a count wrong");
	a_b_low_byte: assert property (s_wr(ADDR_B_LOW) |-> ##2
		ctrl_o.b_count[7:0] == $past(req_i.wdata, 2)) else $error("b low wrong");
	a_b_high_bits: assert property (s_wr(ADDR_B_HIGH) |-> ##2
		ctrl_o.b_count[12:8] == $past(req_i.wdata[4:0], 2)) else $error("b high wrong");
	// unmapped reads still answer, with zero data
	a_unmapped_read: assert property (req_i.rd && (req_i.addr < ADDR_PUMP_POWER
		|| req_i.addr > ADDR_B_HIGH) |=> rvalid_o && rdata_o == 8'h00)
		else $error("unmapped read not zero");
	// reset must be watched while it is active
	a_reset_dividers: assert property (disable iff (1'b0) !nrst_i |=>
		ctrl_o.ref_divide == 14'h0001 && ctrl_o.b_count == 13'h0003 && ctrl_o.a_count == 6'h00)
		else $error("divider reset values wrong");
	// pump normal and asynchronous power-down straight out of reset
	a_reset_controls: assert property (disable iff (1'b0) !nrst_i |=>
		{ctrl_o.charge_pump_up, ctrl_o.charge_pump_down, ctrl_o.charge_pump_hiz,
		ctrl_o.pll_enable, ctrl_o.async_power_down, ctrl_o.sync_power_down} == 6'h32)
		else $error("pump or power reset wrong");
endmodule : pll_divider_config_props

bind pll_divider_config pll_divider_config_props props_u (.clk_sys_i(clk_sys_i),
	.nrst_i(nrst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ctrl_o(ctrl_o));

// [verification/test_pll_divider_config.sv]
// bench for the pll divider configuration slice
// assumes only the byte request port; no partner on the far side
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module test_pll_divider_config
	import pll_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and rows: address, write data, readback, pump and power lines
	logic        clk_sys_i = 1'b0; // 250 MHz
	logic        nrst_i    = 1'b0; // held low at start
	reg_req_s    req_i     = '0;   // request
	logic [7:0]  rdata_o;
	logic        rvalid_o;
	pll_ctrl_s   ctrl_o;
	logic [5:0]  pump_lines;       // up, down, hiz, enable, async, sync
	int          failures, checks, cycles;
	logic [31:0] rows [12] = '{
		{10'h010, 8'h70, 8'h70, 6'h0c}, {10'h010, 8'h75, 8'h75, 6'h22},
		{10'h010, 8'h7a, 8'h7a, 6'h10}, {10'h010, 8'h7f, 8'h7f, 6'h31},
		{10'h011, 8'hff, 8'hff, 6'h31}, {10'h012, 8'hff, 8'h3f, 6'h31},
		{10'h013, 8'hff, 8'h3f, 6'h31}, {10'h014, 8'ha5, 8'ha5, 6'h31},
		{10'h015, 8'hff, 8'h1f, 6'h31}, {10'h016, 8'hff, 8'h00, 6'h31},
		{10'h00f, 8'hff, 8'h00, 6'h31}, {10'h010, 8'h7d, 8'h7d, 6'h32}};
	logic [7:0]  rst_vals [6] = '{RST_PUMP_POWER, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};

	always #2 clk_sys_i = ~clk_sys_i;

	pll_divider_config dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .ctrl_o(ctrl_o));

	// pump and power lines gathered for one compare
	assign pump_lines = {ctrl_o.charge_pump_up, ctrl_o.charge_pump_down,
		ctrl_o.charge_pump_hiz, ctrl_o.pll_enable, ctrl_o.async_power_down,
		ctrl_o.sync_power_down};

	// ==========================================================
	// one request for one cycle; sampled just after the answer edge
	task automatic op(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		req_i <= {w, r, a, d};
		@(posedge clk_sys_i);
		req_i <= '0;
		#1;
	endtask : op

	task automatic conclude();
		$display("failures %0d checks %0d", failures, checks);
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// cut a hang short; the run needs about 75 cycles
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			conclude();
		end
	end

	// ==========================================================
	// table pass, mid-run reset, read and write colliding
	initial begin
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		foreach (rows[i]) begin
			op(1'b1, 1'b0, rows[i][31:22], rows[i][21:14]);
			op(1'b0, 1'b1, rows[i][31:22], 8'h00);
			`CHK("readback", rows[i][13:6], rdata_o)
			`CHK("rvalid", 1'b1, rvalid_o)
			`CHK("pump power lines", rows[i][5:0], pump_lines)
		end
		`CHK("ref_divide", 14'h3fff, ctrl_o.ref_divide)
		`CHK("b_count", 13'h1fa5, ctrl_o.b_count)
		`CHK("a_count", 6'h3f, ctrl_o.a_count)
		@(posedge clk_sys_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		`CHK("ref in reset", 14'h0001, ctrl_o.ref_divide)
		`CHK("lines in reset", 6'h32, pump_lines)
		@(posedge clk_sys_i);
		nrst_i <= 1'b1;
		foreach (rst_vals[i]) begin
			op(1'b0, 1'b1, ADDR_PUMP_POWER + 10'(i), 8'h00);
			`CHK("reset value", rst_vals[i], rdata_o)
		end
		`CHK("pump power", 6'h32, pump_lines)
		`CHK("ref after reset", 14'h0001, ctrl_o.ref_divide)
		op(1'b1, 1'b1, ADDR_REF_LOW, 8'h20);
		`CHK("old on collision", 8'h01, rdata_o)
		op(1'b0, 1'b1, ADDR_REF_LOW, 8'h00);
		`CHK("new low byte", 8'h20, rdata_o)
		`CHK("ref_divide", 14'h0020, ctrl_o.ref_divide)
		conclude();
	end
endmodule : test_pll_divider_config
